/* File: core/kpi_pkg.sv */
// Package for the keyboard pin interrupt block: register map, fields, resets.
// Assumes a 32-bit APB slave with one aligned word per register.
package kpi_pkg;
    localparam int KPI_PINS = 8;
    localparam int KPI_AW = 4;
    // Byte addresses of the registers
    localparam logic [3:0] KPI_ADDR_SC = 4'h0;
    localparam logic [3:0] KPI_ADDR_PE = 4'h4;
    localparam logic [3:0] KPI_ADDR_ES = 4'h8;
    localparam logic [3:0] KPI_ADDR_RAW = 4'hc;
    // Status and control field positions
    localparam int KPI_SC_MODE = 0;
    localparam int KPI_SC_IE = 1;
    localparam int KPI_SC_ACK = 2;
    localparam int KPI_SC_FLAG = 3;
    // Reset values
    localparam logic [7:0] KPI_RST_PE = 8'h00;
    localparam logic [7:0] KPI_RST_ES = 8'h00;
    localparam logic KPI_RST_IE = 1'b0;
    localparam logic KPI_RST_MODE = 1'b0;
    localparam logic [7:0] KPI_RST_SYNC = 8'h00;
endpackage

/* File: core/kpi_sync.sv */
// Three-stage input synchroniser with agreement filter, one per pin vector.
// Assumes inputs are asynchronous to pclk; output is a settled level.
module kpi_sync (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic [kpi_pkg::KPI_PINS-1:0] raw_in, // Pins from outside
    input wire logic [kpi_pkg::KPI_PINS-1:0] rst_val, // Reset level (constant)
    output logic [kpi_pkg::KPI_PINS-1:0] sync_out // Settled level
);
    import kpi_pkg::*;
    logic [KPI_PINS-1:0] s1_ff;
    logic [KPI_PINS-1:0] s2_ff;
    logic [KPI_PINS-1:0] s3_ff;
    logic [KPI_PINS-1:0] out_ff;

    // Chain; only s2 reads s1 so no logic sees a metastable value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= KPI_RST_SYNC;
            s2_ff <= KPI_RST_SYNC;
            s3_ff <= KPI_RST_SYNC;
        end else begin
            s1_ff <= raw_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A change counts only when stage two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= KPI_RST_SYNC;
        end else begin
            out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
        end
    end

    assign sync_out = out_ff;
endmodule

/* File: core/kpi_apb.sv */
// APB slave front end: decodes a transfer into one-cycle write/read strobes.
// Assumes a compliant APB master; answers with one wait state.
module kpi_apb (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [31:0] paddr, // Byte address
    output logic wr_stb, // Write takes effect this cycle
    output logic rd_stb, // Read data sampled this cycle
    output logic [kpi_pkg::KPI_AW-1:0] reg_addr, // Byte address in block
    output logic addr_ok // Address maps to a register
);
    import kpi_pkg::*;
    logic acc;
    logic wait_ff;

    // Read data is captured at the first access edge; a write lands only at
    // the completing edge, so one transfer can never acknowledge twice
    assign acc = psel & penable;
    assign wr_stb = acc & wait_ff & pwrite & addr_ok;
    assign rd_stb = acc & ~wait_ff & ~pwrite;
    assign reg_addr = paddr[KPI_AW-1:0];

    // Mirrors the ready flop of the top: high during the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= acc & ~wait_ff;
        end
    end

    // Only the four word addresses in the low window are mapped
    always_comb begin
        if (paddr[31:KPI_AW] != 28'h0000000) begin
            addr_ok = 1'b0;
        end else if (reg_addr == KPI_ADDR_SC) begin
            addr_ok = 1'b1;
        end else if (reg_addr == KPI_ADDR_PE) begin
            addr_ok = 1'b1;
        end else if (reg_addr == KPI_ADDR_ES) begin
            addr_ok = 1'b1;
        end else if (reg_addr == KPI_ADDR_RAW) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end
endmodule

/* File: core/kpi_top.sv */
// Keyboard pin interrupt block: eight sensed pins, one shared event flag,
// one interrupt request, pull direction steering. APB register access.
// Assumes pins are asynchronous; stop-mode control comes from the system.
// Overview of operation
// - Keeps running during background debug halt
// - Status bits 7:4 read zero
// - Flag bit 3, writes cannot change it
// - Acknowledge bit 2, write-one clears, reads zero
// - Interrupt enable bit 1 gates request
// - Mode bit 0: edges, or edges plus levels
// - Pin enable bits enable each pin
// - Polarity: 0 falling/low, 1 rising/high
// - Falling edge: high then low sample
// - Rising edge: low then high sample
// - All inputs deassert before next edge
// - Edge sets flag; enable raises request
// - Edge mode: acknowledge clears flag
// - Level mode: edge or level sets flag
// - Level mode: clear only if all deasserted
// - Polarity steers pull-up or pull-down
// - Deep stop disables and resets block
module kpi_top (
    input wire logic pclk, // Bus clock 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic deep_stop, // Deepest stop modes active
    input wire logic [kpi_pkg::KPI_PINS-1:0] wake_input_pin, // Sensed pins
    input wire logic [kpi_pkg::KPI_PINS-1:0] port_pull_enable, // Port pull enables
    output logic key_irq, // Interrupt request to CPU
    output logic [kpi_pkg::KPI_PINS-1:0] pull_up_on, // Pull-up active per pin
    output logic [kpi_pkg::KPI_PINS-1:0] pull_down_on // Pull-down active per pin
);
    import kpi_pkg::*;

    logic [KPI_PINS-1:0] pin_sense_enable_ff;
    logic [KPI_PINS-1:0] pin_polarity_select_ff;
    logic key_irq_enable_ff;
    logic level_detect_select_ff;
    logic key_event_flag_ff;
    logic [KPI_PINS-1:0] prev_assert_ff;
    logic armed_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic key_irq_ff;
    logic [KPI_PINS-1:0] pull_up_ff;
    logic [KPI_PINS-1:0] pull_down_ff;

    logic [KPI_PINS-1:0] pins_sync;
    logic [KPI_PINS-1:0] asserted;
    logic any_asserted;
    logic edge_hit;
    logic level_hit;
    logic wr_stb;
    logic rd_stb;
    logic [KPI_AW-1:0] reg_addr;
    logic addr_ok;
    logic ack_wr;
    logic wr_sc;
    logic wr_pe;
    logic wr_es;
    logic blk_rst;
    logic [31:0] nxt_prdata;

    // Level seen as asserted for each pin given its polarity
    function automatic logic [KPI_PINS-1:0] sense_level(input logic [KPI_PINS-1:0] lvl,
                                                         input logic [KPI_PINS-1:0] pol);
        sense_level = ~(lvl ^ pol);
    endfunction

    // Word decode shared by the write strobes
    function automatic logic reg_hit(input logic [KPI_AW-1:0] addr, input logic [KPI_AW-1:0] want);
        reg_hit = (addr == want);
    endfunction

    // Resistor steering for one direction: pull on, pin enabled, sense match
    function automatic logic [KPI_PINS-1:0] steer_pull(input logic [KPI_PINS-1:0] pull_en,
                                                        input logic [KPI_PINS-1:0] pin_en,
                                                        input logic [KPI_PINS-1:0] dir);
        steer_pull = pull_en & pin_en & dir;
    endfunction

    kpi_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw_in(wake_input_pin),
        .rst_val(KPI_RST_SYNC),
        .sync_out(pins_sync)
    );

    kpi_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_addr(reg_addr),
        .addr_ok(addr_ok)
    );

    // Deep stop holds every register but the synchroniser and bus flops at its reset value, so waking
    // from it leaves the block as after reset. Shallow-stop asynchronous
    // wake detection is not modelled: the bus clock is assumed to run.
    assign blk_rst = deep_stop;

    // A disabled pin counts as deasserted, so enabling a pin that already
    // sits at its asserted level can raise a false flag; the safe set-up
    // order acknowledges it before the request is enabled.

    // Detection: no debug-halt input exists, so it never stops.
    assign asserted = sense_level(pins_sync, pin_polarity_select_ff) & pin_sense_enable_ff;
    assign any_asserted = |asserted;
    // Edge is deasserted last cycle, asserted now, only once rearmed
    assign edge_hit = armed_ff & |(asserted & ~prev_assert_ff);
    assign level_hit = level_detect_select_ff & any_asserted;
    // Register write strobes, one per writable word; the raw view has none
    assign wr_sc = wr_stb && reg_hit(reg_addr, KPI_ADDR_SC);
    assign wr_pe = wr_stb && reg_hit(reg_addr, KPI_ADDR_PE);
    assign wr_es = wr_stb && reg_hit(reg_addr, KPI_ADDR_ES);
    assign ack_wr = wr_sc && pwdata[KPI_SC_ACK];

    // Previous-cycle asserted view; disabled pins count as deasserted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_assert_ff <= KPI_RST_SYNC;
        end else if (blk_rst) begin
            prev_assert_ff <= KPI_RST_SYNC;
        end else begin
            prev_assert_ff <= asserted;
        end
    end

    // Rearm only when all enabled inputs are back at deasserted level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff <= 1'b0;
        end else if (blk_rst) begin
            armed_ff <= 1'b0;
        end else if (edge_hit) begin
            armed_ff <= 1'b0;
        end else if (!any_asserted) begin
            armed_ff <= 1'b1;
        end
    end

    // Event flag: set wins over acknowledge; an asserted pin in level mode blocks the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_event_flag_ff <= 1'b0;
        end else if (blk_rst) begin
            key_event_flag_ff <= 1'b0;
        end else if (edge_hit || level_hit) begin
            key_event_flag_ff <= 1'b1;
        end else if (ack_wr) begin
            key_event_flag_ff <= 1'b0;
        end
    end

    // Interrupt enable; the flag bit of a status write is ignored.
    // Cleared first in the safe set-up order so no early request escapes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_irq_enable_ff <= KPI_RST_IE;
        end else if (blk_rst) begin
            key_irq_enable_ff <= KPI_RST_IE;
        end else if (wr_sc) begin
            key_irq_enable_ff <= pwdata[KPI_SC_IE];
        end
    end

    // Detection mode: edges only, or edges plus held levels.
    // Changing it with a pin asserted may set the flag at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_detect_select_ff <= KPI_RST_MODE;
        end else if (blk_rst) begin
            level_detect_select_ff <= KPI_RST_MODE;
        end else if (wr_sc) begin
            level_detect_select_ff <= pwdata[KPI_SC_MODE];
        end
    end

    // Pin enables; a disabled pin never asserts.
    // They also gate the pull steering, so a disabled pin floats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sense_enable_ff <= KPI_RST_PE;
        end else if (blk_rst) begin
            pin_sense_enable_ff <= KPI_RST_PE;
        end else if (wr_pe) begin
            pin_sense_enable_ff <= pwdata[KPI_PINS-1:0];
        end
    end

    // Polarity per pin: sense of edge and level, and pull direction.
    // Set before enabling pins, or the old sense may flag a false event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_polarity_select_ff <= KPI_RST_ES;
        end else if (blk_rst) begin
            pin_polarity_select_ff <= KPI_RST_ES;
        end else if (wr_es) begin
            pin_polarity_select_ff <= pwdata[KPI_PINS-1:0];
        end
    end

    // Read mux; the raw pin view helps software ordering
    always_comb begin
        nxt_prdata = 32'h00000000;
        if (!addr_ok) begin
            nxt_prdata = 32'h00000000;
        end else if (reg_addr == KPI_ADDR_SC) begin
            nxt_prdata[KPI_SC_FLAG] = key_event_flag_ff;
            nxt_prdata[KPI_SC_IE] = key_irq_enable_ff;
            nxt_prdata[KPI_SC_MODE] = level_detect_select_ff; // ack reads zero
        end else if (reg_addr == KPI_ADDR_PE) begin
            nxt_prdata[KPI_PINS-1:0] = pin_sense_enable_ff;
        end else if (reg_addr == KPI_ADDR_ES) begin
            nxt_prdata[KPI_PINS-1:0] = pin_polarity_select_ff;
        end else begin
            nxt_prdata[KPI_PINS-1:0] = pins_sync;
        end
    end

    // Read data is registered at the first access edge and shown one cycle
    // later with pready; it holds until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_stb) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // One wait state on every transfer: a two-cycle access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
        end
    end

    // Error rides with ready for any unmapped word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
        end
    end

    // Request from a flop so it never glitches while flag or enable change;
    // it trails the flag by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_irq_ff <= 1'b0;
        end else begin
            key_irq_ff <= key_event_flag_ff & key_irq_enable_ff & ~blk_rst;
        end
    end

    // Pull-up where the pin senses falling edges or low levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_ff <= 8'h00;
        end else begin
            pull_up_ff <= steer_pull(port_pull_enable, pin_sense_enable_ff, ~pin_polarity_select_ff);
        end
    end

    // Pull-down where the pin senses rising edges or high levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_down_ff <= 8'h00;
        end else begin
            pull_down_ff <= steer_pull(port_pull_enable, pin_sense_enable_ff, pin_polarity_select_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign key_irq = key_irq_ff;
    assign pull_up_on = pull_up_ff;
    assign pull_down_on = pull_down_ff;
endmodule

/* File: verification/kpi_properties.sv */
// Checker for the key sense block: bus timing, status readback, request gating.
// Assumes one wait state per access and register writes at the ready edge.
module kpi_properties (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [31:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic deep_stop, // Deep stop
    input wire logic [kpi_pkg::KPI_PINS-1:0] wake_input_pin, // Pins
    input wire logic [kpi_pkg::KPI_PINS-1:0] port_pull_enable, // Pull enables
    input wire logic key_irq, // Request
    input wire logic [kpi_pkg::KPI_PINS-1:0] pull_up_on, // Pull-ups
    input wire logic [kpi_pkg::KPI_PINS-1:0] pull_down_on // Pull-downs
);
    import kpi_pkg::*;
    logic [7:0] pe_sh;
    logic [7:0] pol_sh;
    logic ie_sh;
    logic wr_stb;
    logic wr_sc;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || deep_stop);
    // Writes land on the completing edge, where ready is sampled high
    assign wr_stb = psel && penable && pwrite && pready;
    assign wr_sc = wr_stb && paddr == 32'(KPI_ADDR_SC);
    // Shadow of the set-up, since the checker cannot see inside the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_sh <= KPI_RST_PE;
            pol_sh <= KPI_RST_ES;
            ie_sh <= KPI_RST_IE;
        end else if (deep_stop) begin
            pe_sh <= KPI_RST_PE;
            pol_sh <= KPI_RST_ES;
            ie_sh <= KPI_RST_IE;
        end else begin
            pe_sh <= (wr_stb && paddr == 32'(KPI_ADDR_PE)) ? pwdata[7:0] : pe_sh;
            pol_sh <= (wr_stb && paddr == 32'(KPI_ADDR_ES)) ? pwdata[7:0] : pol_sh;
            ie_sh <= wr_sc ? pwdata[KPI_SC_IE] : ie_sh;
        end
    end
    AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access edge");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_SLVERR: assert property (pready |-> pslverr == (paddr[31:4] != 28'h0 || paddr[1:0] != 2'h0))
        else $error("error flag wrong for address");
    AST_SC_ZERO: assert property (pready && !pwrite && paddr == 32'(KPI_ADDR_SC) |->
        prdata[31:4] == 28'h0 && !prdata[KPI_SC_ACK]) else $error("status reads nonzero in fixed bits");
    AST_IRQ_GATE: assert property (key_irq |-> $past(ie_sh))
        else $error("request while disabled");
    AST_IRQ_HOLD: assert property (key_irq && !wr_sc && !$past(wr_sc) |=> key_irq)
        else $error("request dropped without acknowledge");
    AST_PULL_UP: assert property (pull_up_on == $past(port_pull_enable & pe_sh & ~pol_sh))
        else $error("pull-up steering wrong");
    AST_PULL_DOWN: assert property (pull_down_on == $past(port_pull_enable & pe_sh & pol_sh))
        else $error("pull-down steering wrong");
    COV_IRQ: cover property (key_irq);
    COV_ERR: cover property (pready && pslverr);
    COV_LEVEL: cover property (pready && !pwrite && paddr == 32'(KPI_ADDR_SC) && prdata[KPI_SC_MODE] && prdata[KPI_SC_FLAG]);
endmodule

bind kpi_top kpi_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_stop(deep_stop), .wake_input_pin(wake_input_pin), .port_pull_enable(port_pull_enable),
    .key_irq(key_irq), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on));

/* File: verification/kpi_pin_model.sv */
// Far-side model: switch or wake lines on the sensed pins.
// Assumes the bench says which lines are driven and to what level.
module kpi_pin_model (
    input wire logic pclk, // Paces the floating pattern
    input wire logic [7:0] drv_en, // Line driven
    input wire logic [7:0] drv_val, // Driven level
    input wire logic [7:0] pull_up_on, // Pull-ups
    input wire logic [7:0] pull_down_on, // Pull-downs
    output logic [7:0] pin_lvl // Line level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_ff = 8'h5a;
    // A floating line has no level, so show one that keeps changing
    always_ff @(posedge pclk) begin
        float_ff <= ~float_ff;
    end
    // Driver wins, then whichever resistor the polarity chose
    always_comb begin
        pin_lvl = (drv_en & drv_val) | (~drv_en & (pull_up_on | (~pull_down_on & float_ff)));
    end
endmodule

/* File: verification/tb_top.sv */
// Bench for the key sense block: APB register tasks and pin scenarios.
// Assumes the pin model on the sensed lines and the checker bound to the top.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import kpi_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic deep_stop = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] port_pull_enable = 8'h00;
    logic [7:0] drv_en = 8'h00;
    logic [7:0] drv_val = 8'h00;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, key_irq, rerr;
    logic [7:0] pin_lvl, pull_up_on, pull_down_on;
    int num_errors = 0;
    int tests_run = 0;
    always #5 pclk = ~pclk;
    kpi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .deep_stop(deep_stop), .wake_input_pin(pin_lvl), .port_pull_enable(port_pull_enable),
        .key_irq(key_irq), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on));
    kpi_pin_model u_pins (.pclk(pclk), .drv_en(drv_en), .drv_val(drv_val), .pull_up_on(pull_up_on),
        .pull_down_on(pull_down_on), .pin_lvl(pin_lvl));
    // One APB transfer; the wait for ready is bounded by the watchdog
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Long enough for the synchroniser plus flag and request stages
    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask
    task automatic press(input int i, input logic v);
        drv_en[i] <= 1'b1;
        drv_val[i] <= v;
        settle();
    endtask
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(32'(KPI_ADDR_SC), 32'h0);
        rd(32'(KPI_ADDR_PE), 32'(KPI_RST_PE));
        rd(32'(KPI_ADDR_ES), 32'(KPI_RST_ES));
        rd(32'h10, 32'h0);
        chk(32'(rerr), 32'h1);
        // Safe set-up order; lines float until pulls engage, so a false flag is possible
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h0);
        xfer(1'b1, 32'(KPI_ADDR_ES), 32'h0f);
        port_pull_enable <= 8'hff;
        xfer(1'b1, 32'(KPI_ADDR_PE), 32'hff);
        settle();
        chk(32'(pull_up_on), 32'hf0);
        chk(32'(pull_down_on), 32'h0f);
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h06);
        rd(32'(KPI_ADDR_SC), 32'h02);
        rd(32'(KPI_ADDR_RAW), 32'hf0);
        press(5, 1'b0);
        chk(32'(key_irq), 32'h1);
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h02);
        rd(32'(KPI_ADDR_SC), 32'h0a);
        // Line 1 rises while line 5 is still held, so nothing is rearmed
        press(1, 1'b1);
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h06);
        settle();
        rd(32'(KPI_ADDR_SC), 32'h02);
        drv_en <= 8'h00;
        settle();
        press(2, 1'b1);
        rd(32'(KPI_ADDR_SC), 32'h0a);
        drv_en <= 8'h00;
        xfer(1'b1, 32'(KPI_ADDR_PE), 32'hfb);
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h06);
        press(2, 1'b1);
        rd(32'(KPI_ADDR_SC), 32'h02);
        drv_val <= 8'h00;
        xfer(1'b1, 32'(KPI_ADDR_PE), 32'hff);
        drv_en <= 8'h00;
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h04);
        press(6, 1'b0);
        chk(32'(key_irq), 32'h0);
        rd(32'(KPI_ADDR_SC), 32'h08);
        drv_en <= 8'h00;
        settle();
        // Level mode: an acknowledge while line 0 is held must not clear
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h07);
        press(0, 1'b1);
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h07);
        rd(32'(KPI_ADDR_SC), 32'h0b);
        drv_en <= 8'h00;
        settle();
        xfer(1'b1, 32'(KPI_ADDR_SC), 32'h07);
        rd(32'(KPI_ADDR_SC), 32'h03);
        chk(32'(key_irq), 32'h0);
        deep_stop <= 1'b1;
        settle();
        deep_stop <= 1'b0;
        rd(32'(KPI_ADDR_PE), 32'h0);
        rd(32'(KPI_ADDR_SC), 32'h0);
        finish_test();
    end
endmodule
